/* src/obc_decoder.sv */
// option byte latch, decode and flash access gating
module obc_decoder (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic [7:0] OPT0_NV_I,
   input wire logic [7:0] OPT1_NV_I,
   input wire logic PROG_MODE_I,
   input wire logic OPT_WR_I,
   input wire logic OPT_ERASE_I,
   input wire logic [7:0] OPT0_WDATA_I,
   input wire logic [7:0] OPT1_WDATA_I,
   input wire logic MEM_RD_I,
   input wire logic MEM_WR_I,
   input wire logic DEBUG_RD_I,
   input wire logic [7:0] MEM_RDATA_I,
   input wire logic MEM_BLANK_I,
   output logic [$bits(obc_pkg::obc_cfg_s)-1:0] CFG_O,
   output logic OPT_WR_O,
   output logic OPT_ERASE_O,
   output logic [7:0] OPT0_WDATA_O,
   output logic [7:0] OPT1_WDATA_O,
   output logic MEM_WR_O,
   output logic MEM_MASS_ERASE_O,
   output logic [7:0] MEM_RDATA_O,
   output logic ACCESS_DENIED_O,
   output logic [7:0] OPT0_RD_O,
   output logic [7:0] OPT1_RD_O
);
   import obc_pkg::*;

   //---------------------------------------------------------------
   // decode
   //---------------------------------------------------------------
   function automatic obc_cfg_s decode(input logic [7:0] b0,
                                       input logic [7:0] b1);
      obc_cfg_s c;
      c.startup_clock_select = obc_clk_e'(b1[B1_START_HI:B1_START_LO]); // [R1]
      c.multiplier_enable = ~b1[B1_MULT]; // [R3]
      c.low_voltage_detect_sel = obc_det_e'(b1[B1_DET_HI:B1_DET_LO]); // [R4]
      c.watchdog_hw_enable = ~b1[B1_WDSW]; // [R5]
      c.watchdog_reset_on_halt = b1[B1_WDHALT]; // [R6]
      c.wakeup_clock_select = b0[B0_WAKE]; // [R7]
      // range only meaningful for external sources
      c.oscillator_range = b1[B1_START_HI] ?
         b0[B0_RANGE_HI:B0_RANGE_LO] : RANGE_SLOW_OSC; // [R9]
      // size in half-kilobyte units: 1,2,4,8
      c.sector0_size_kb_x2 = 4'h1 << b0[B0_SIZE_HI:B0_SIZE_LO]; // [R11]
      c.readout_protect = b0[B0_RDP]; // [R12]
      c.write_protect = b0[B0_WRP]; // [R14]
      return c;
   endfunction : decode

   //---------------------------------------------------------------
   // latched option bytes
   //---------------------------------------------------------------
   logic [7:0] opt0, opt1;
   logic loaded;
   logic [7:0] next_opt0, next_opt1;
   logic next_loaded;

   // bytes sampled once after release and then frozen until reset
   always_comb begin
      next_opt0 = opt0;
      next_opt1 = opt1;
      next_loaded = 1'b1;
      if (!loaded) begin
         next_opt0 = OPT0_NV_I; // [R17]
         next_opt1 = OPT1_NV_I; // [R17]
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         opt0 <= OPT0_RESET;
         opt1 <= OPT1_RESET;
         loaded <= 1'b0;
      end else begin
         opt0 <= next_opt0;
         opt1 <= next_opt1;
         loaded <= next_loaded;
      end
   end

   //---------------------------------------------------------------
   // access gating
   //---------------------------------------------------------------
   obc_cfg_s cfg;
   logic next_opt_wr, next_opt_erase, next_mem_wr, next_mass;
   logic next_denied;
   logic [7:0] next_rdata, next_w0, next_w1;
   logic next_opt_wr_q, next_opt_erase_q, next_mem_wr_q, next_mass_q;
   logic next_denied_q;

   assign cfg = decode(opt0, opt1);

   always_comb begin
      next_opt_wr = 1'b0;
      next_opt_erase = 1'b0;
      next_mass = 1'b0;
      next_mem_wr = 1'b0;
      next_denied = 1'b0;
      next_w0 = OPT0_WDATA_I;
      next_w1 = OPT1_WDATA_I;
      next_rdata = MEM_RDATA_I;
      if (OPT_WR_I || OPT_ERASE_I) begin
         if (!PROG_MODE_I || cfg.write_protect) begin
            next_denied = 1'b1; // [R15] [R14]
         end else if (OPT_ERASE_I) begin
            // wipe memory before options lose their protection
            if (cfg.readout_protect && !MEM_BLANK_I) begin
               next_mass = 1'b1; // [R13]
            end else begin
               next_opt_erase = 1'b1; // [R13]
            end
         end else begin
            next_opt_wr = 1'b1;
         end
      end
      if (MEM_WR_I) begin
         if (cfg.write_protect || cfg.readout_protect) begin
            next_denied = 1'b1; // [R12] [R14]
         end else begin
            next_mem_wr = 1'b1;
         end
      end
      if (MEM_RD_I && DEBUG_RD_I && cfg.readout_protect) begin
         // blank data, never real content, to an external reader
         next_rdata = ERASED_BYTE; // [R12] [R16]
         next_denied = 1'b1;
      end
   end

   assign next_opt_wr_q = next_opt_wr;
   assign next_opt_erase_q = next_opt_erase;
   assign next_mem_wr_q = next_mem_wr;
   assign next_mass_q = next_mass;
   assign next_denied_q = next_denied;

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         CFG_O <= decode(OPT0_RESET, OPT1_RESET);
         OPT_WR_O <= 1'b0;
         OPT_ERASE_O <= 1'b0;
         MEM_WR_O <= 1'b0;
         MEM_MASS_ERASE_O <= 1'b0;
         ACCESS_DENIED_O <= 1'b0;
         OPT0_WDATA_O <= 8'h00;
         OPT1_WDATA_O <= 8'h00;
         MEM_RDATA_O <= ERASED_BYTE;
         OPT0_RD_O <= OPT0_RESET;
         OPT1_RD_O <= OPT1_RESET;
      end else begin
         CFG_O <= cfg;
         OPT_WR_O <= next_opt_wr_q;
         OPT_ERASE_O <= next_opt_erase_q;
         MEM_WR_O <= next_mem_wr_q;
         MEM_MASS_ERASE_O <= next_mass_q;
         ACCESS_DENIED_O <= next_denied_q;
         OPT0_WDATA_O <= next_w0;
         OPT1_WDATA_O <= next_w1;
         MEM_RDATA_O <= next_rdata;
         // option readback only visible to the programmer
         OPT0_RD_O <= PROG_MODE_I ? opt0 : 8'h00; // [R15]
         OPT1_RD_O <= PROG_MODE_I ? opt1 : 8'h00; // [R15]
      end
   end
endmodule : obc_decoder

/* src/obc_pkg.sv */
// shared constants and types for the option byte configuration decoder
//------------------------------------------------------------------------
// Behaviour
// R1: byte1 bits 7:6 pick startup clock
// R2: programmer always writes byte1 bit 5 as one
// R3: byte1 bit 4 zero enables multiplier
// R4: byte1 bits 3:2 pick detector threshold
// R5: byte1 bit 1 zero forces hardware watchdog
// R6: byte1 bit 0 one resets on halt
// R7: byte0 bit 7 picks wakeup clock source
// R8: wakeup bit clear needs range 100
// R9: byte0 bits 6:4 pick oscillator range
// R10: programmer keeps defaults for internal startup
// R11: byte0 bits 3:2 give sector 0 size
// R12: byte0 bit 1 blocks readout and writes
// R13: erase under readout protect wipes memory first
// R14: byte0 bit 0 locks flash forever
// R15: option bytes reachable only in programming mode
// R16: shipped program memory reads ff
// R17: bytes latched at reset, fields then stable
//------------------------------------------------------------------------
package obc_pkg;
   localparam int OPT_W = 8;
   // byte 1 fields
   localparam int B1_START_HI = 7;
   localparam int B1_START_LO = 6;
   localparam int B1_RES = 5;
   localparam int B1_MULT = 4;
   localparam int B1_DET_HI = 3;
   localparam int B1_DET_LO = 2;
   localparam int B1_WDSW = 1;
   localparam int B1_WDHALT = 0;
   // byte 0 fields
   localparam int B0_WAKE = 7;
   localparam int B0_RANGE_HI = 6;
   localparam int B0_RANGE_LO = 4;
   localparam int B0_SIZE_HI = 3;
   localparam int B0_SIZE_LO = 2;
   localparam int B0_RDP = 1;
   localparam int B0_WRP = 0;
   // reset (default) values
   localparam logic [7:0] OPT0_RESET = 8'hfc;
   localparam logic [7:0] OPT1_RESET = 8'h3f;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [2:0] RANGE_SLOW_OSC = 3'h4;

   typedef enum logic [1:0] {
      CLK_INT_RC = 2'h0,
      CLK_WAKE_RC = 2'h1,
      CLK_XTAL = 2'h2,
      CLK_EXT = 2'h3
   } obc_clk_e;

   typedef enum logic [1:0] {
      DET_LOW = 2'h0,
      DET_MED = 2'h1,
      DET_HIGH = 2'h2,
      DET_OFF = 2'h3
   } obc_det_e;

   typedef struct packed {
      obc_clk_e startup_clock_select;
      logic multiplier_enable;
      obc_det_e low_voltage_detect_sel;
      logic watchdog_hw_enable;
      logic watchdog_reset_on_halt;
      logic wakeup_clock_select;
      logic [2:0] oscillator_range;
      logic [3:0] sector0_size_kb_x2;
      logic readout_protect;
      logic write_protect;
   } obc_cfg_s;
endpackage : obc_pkg

/* testbench/obc_assertions.sv */
// port checker for the option byte decoder
module obc_assertions (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic PROG_MODE_I,
   input wire logic OPT_WR_I,
   input wire logic OPT_ERASE_I,
   input wire logic MEM_WR_I,
   input wire logic MEM_RD_I,
   input wire logic DEBUG_RD_I,
   input wire logic MEM_BLANK_I,
   input wire logic [16:0] CFG_O,
   input wire logic OPT_WR_O,
   input wire logic MEM_WR_O,
   input wire logic MEM_MASS_ERASE_O,
   input wire logic ACCESS_DENIED_O,
   input wire logic [7:0] MEM_RDATA_O,
   input wire logic [7:0] OPT0_RD_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);
   logic [1:0] age, next_age;
   // cfg settles two edges after release
   always_comb next_age = age + {1'b0, age != 2'h3};
   always_ff @(posedge CLOCK_I or posedge RST_I)
      if (RST_I) age <= 2'h0;
      else age <= next_age;
   sequence s_lock;
      PROG_MODE_I && OPT_ERASE_I && CFG_O[1] && !CFG_O[0] && !MEM_BLANK_I;
   endsequence
   property p_ref; OPT_WR_I && !PROG_MODE_I |=> ACCESS_DENIED_O; endproperty
   a_ref: assert property (p_ref) else $error("opt write taken");
   property p_hid; !PROG_MODE_I |=> OPT0_RD_O == 8'h00; endproperty
   a_hid: assert property (p_hid) else $error("opt visible");
   property p_wpl; OPT_WR_I && CFG_O[0] |=> !OPT_WR_O; endproperty
   a_wpl: assert property (p_wpl) else $error("locked write");
   property p_rdw;
      MEM_WR_I && CFG_O[1] |=> !MEM_WR_O && ACCESS_DENIED_O;
   endproperty
   a_rdw: assert property (p_rdw) else $error("protected write");
   property p_rdr;
      MEM_RD_I && DEBUG_RD_I && CFG_O[1] |=> MEM_RDATA_O == 8'hff;
   endproperty
   a_rdr: assert property (p_rdr) else $error("data leaked");
   property p_mass; s_lock |=> MEM_MASS_ERASE_O; endproperty
   a_mass: assert property (p_mass) else $error("no wipe");
   property p_grant; MEM_WR_I && CFG_O[1:0] == 2'h0 |=> MEM_WR_O; endproperty
   a_grant: assert property (p_grant) else $error("write lost");
   property p_hold; age == 2'h3 |-> $stable(CFG_O); endproperty
   a_hold: assert property (p_hold) else $error("cfg moved");
endmodule : obc_assertions
bind obc_decoder obc_assertions i_chk (.*);

/* testbench/obc_prog_tool.sv */
// programming tool model driving option byte writes and erases
module obc_prog_tool (
   input wire logic clk_i,
   output logic wr_o,
   output logic er_o,
   output logic [7:0] d0_o,
   output logic [7:0] d1_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {wr_o, er_o} = 2'h0;
      {d0_o, d1_o} = 16'hfc3f;
   end
   task automatic write(input logic [7:0] b0, input logic [7:0] b1);
      @(posedge clk_i);
      d0_o <= !b0[7] ? {1'b0, 3'h4, b0[3:0]} : b1[7] ? b0 : b0 | 8'h70;
      d1_o <= b1 | 8'h20;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // data is not held once the strobe is gone
      {d0_o, d1_o} <= ~{d0_o, d1_o};
   endtask : write
   task automatic erase;
      @(posedge clk_i);
      er_o <= 1'b1;
      @(posedge clk_i);
      er_o <= 1'b0;
   endtask : erase
endmodule : obc_prog_tool

/* testbench/tb.sv */
// self-checking bench for the option byte decoder
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK_I, RST_I, PROG_MODE_I, OPT_WR_I, OPT_ERASE_I, MEM_RD_I;
   logic MEM_WR_I, DEBUG_RD_I, MEM_BLANK_I, OPT_WR_O, OPT_ERASE_O;
   logic MEM_WR_O, MEM_MASS_ERASE_O, ACCESS_DENIED_O;
   logic [7:0] OPT0_NV_I, OPT1_NV_I, OPT0_WDATA_I, OPT1_WDATA_I;
   logic [7:0] MEM_RDATA_I, OPT0_WDATA_O, OPT1_WDATA_O, MEM_RDATA_O;
   logic [7:0] OPT0_RD_O, OPT1_RD_O;
   logic [16:0] CFG_O;
   int fail_count = 0;
   int checked = 0;
   obc_decoder i_obc_decoder (.*);
   obc_prog_tool i_tool (.clk_i(CLOCK_I), .wr_o(OPT_WR_I),
      .er_o(OPT_ERASE_I), .d0_o(OPT0_WDATA_I), .d1_o(OPT1_WDATA_I));
   initial begin
      CLOCK_I = 1'b0;
      forever #5 CLOCK_I = ~CLOCK_I;
   end
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [16:0] dec(input logic [7:0] b0, b1);
      return {b1[7:6], ~b1[4], b1[3:2], ~b1[1], b1[0], b0[7],
         b1[7] ? b0[6:4] : 3'h4, 4'h1 << b0[3:2], b0[1:0]};
   endfunction : dec
   task automatic boot(input logic [7:0] b0, input logic [7:0] b1);
      @(posedge CLOCK_I);
      {OPT0_NV_I, OPT1_NV_I} <= {b0, b1};
      RST_I <= 1'b1;
      repeat (6) @(posedge CLOCK_I);
      chk(MEM_RDATA_O, 8'hff);
      RST_I <= 1'b0;
      repeat (3) @(posedge CLOCK_I);
      chk(CFG_O, dec(b0, b1));
   endtask : boot
   task automatic t_decode;
      for (int i = 0; i < 8; i++) begin
         boot({1'b1, i[2:0], i[1:0], 2'h0}, {i[1:0], 1'b1, i[2], i[1:0], i[0], i[2]});
      end
      boot(8'h4c, 8'h3f);
      $display("t_decode done");
   endtask : t_decode
   task automatic t_prog;
      i_tool.write(8'h7c, 8'h1f);
      #1 chk({ACCESS_DENIED_O, OPT_WR_O, OPT0_RD_O}, 10'h200);
      @(posedge CLOCK_I);
      PROG_MODE_I <= 1'b1;
      i_tool.write(8'h7c, 8'h1f);
      #1 chk({OPT_WR_O, OPT0_WDATA_O, OPT1_WDATA_O}, 17'h14c3f);
      chk(CFG_O, dec(8'h4c, 8'h3f));
      @(posedge CLOCK_I);
      {MEM_WR_I, MEM_RD_I} <= 2'h3;
      @(posedge CLOCK_I);
      {MEM_WR_I, MEM_RD_I} <= 2'h0;
      #1 chk({MEM_WR_O, ACCESS_DENIED_O, MEM_RDATA_O}, 10'h25a);
      $display("t_prog done");
   endtask : t_prog
   task automatic t_protect;
      boot(8'hfe, 8'h3f);
      {MEM_WR_I, MEM_RD_I, DEBUG_RD_I} <= 3'h7;
      @(posedge CLOCK_I);
      {MEM_WR_I, MEM_RD_I, DEBUG_RD_I} <= 3'h0;
      #1 chk({MEM_WR_O, ACCESS_DENIED_O, MEM_RDATA_O}, 10'h1ff);
      i_tool.erase();
      #1 chk(MEM_MASS_ERASE_O, 1'b1);
      MEM_BLANK_I <= 1'b1;
      i_tool.erase();
      #1 chk({OPT_ERASE_O, OPT0_RD_O, OPT1_RD_O}, 17'h1fe3f);
      MEM_BLANK_I <= 1'b0;
      boot(8'hfd, 8'h3f);
      i_tool.write(8'hfc, 8'h3f);
      #1 chk({OPT_WR_O, ACCESS_DENIED_O}, 2'h1);
      $display("t_protect done");
   endtask : t_protect
   task automatic end_sim;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   initial begin
      RST_I = 1'b1;
      {PROG_MODE_I, MEM_RD_I, MEM_WR_I, DEBUG_RD_I, MEM_BLANK_I} = 5'h0;
      {OPT0_NV_I, OPT1_NV_I, MEM_RDATA_I} = 24'hfc3f5a;
      t_decode();
      t_prog();
      t_protect();
      end_sim();
   end
   // roughly three times the cycles the tests need
   initial begin
      repeat (400) @(posedge CLOCK_I);
      fail_count++;
      end_sim();
   end
endmodule : tb
